// ===== src/edm_pkg.sv
// Shared constants for the event-driven data movement controller.
package edm_pkg;
  localparam int EV_N = 32;
  localparam logic [31:0] EV_VALID_MASK = 32'hFDFF_FFFF;
  localparam int ENT_TYPE_POS = 0;
  localparam int ENT_PTR_POS = 2;
  localparam int ENT_IRQ_POS = 8;
  localparam logic [1:0] ET_NONE = 2'h0;
  localparam logic [1:0] ET_XFER = 2'h1;
  localparam logic [1:0] ET_INT = 2'h2;
  localparam int XFER_ENTRIES = 8;
  localparam int PRAM_WORDS = 64;
  localparam logic [1:0] XW_SRC = 2'h0;
  localparam logic [1:0] XW_DST = 2'h1;
  localparam logic [1:0] XW_CNT = 2'h2;
  localparam logic [1:0] XW_IDX = 2'h3;
  localparam logic [11:0] REG_TRIGGER = 12'h000;
  localparam logic [11:0] REG_POLARITY = 12'h004;
  localparam logic [11:0] REG_ENABLE = 12'h008;
  localparam logic [11:0] REG_HIGH_GROUP = 12'h00C;
  localparam logic [11:0] REG_PRAM_ADDR = 12'h010;
  localparam logic [11:0] REG_PRAM_DATA = 12'h014;
  localparam logic [11:0] REG_LEVEL = 12'h018;
  localparam logic [11:0] REG_FLAG = 12'h01C;
  localparam logic [11:0] REG_IRQ = 12'h020;
  localparam logic [11:0] REG_BUSY = 12'h024;
  localparam int PRAM_GROUP_POS = 8;
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  localparam logic [31:0] RST_POLARITY = 32'hFFFF_FFFF;
endpackage

// ===== src/edm_link_if.sv
// Link between the CPU-side end and the data movement controller.
`timescale 1ns/10ps
`default_nettype none
interface edm_link_if;
  logic [31:0] cpu_trigger;
  logic [31:0] polarity;
  logic [31:0] enable;
  logic [31:0] high_group;
  logic pram_wr;
  logic pram_group;
  logic [5:0] pram_addr;
  logic [31:0] pram_data;
  logic [31:0] event_level;
  logic [31:0] event_flag;
  logic [1:0] cpu_int;
  logic [7:0] cpu_int_num;
  logic [1:0] busy;
  modport device (
    input cpu_trigger, polarity, enable, high_group,
    input pram_wr, pram_group, pram_addr, pram_data,
    output event_level, event_flag, cpu_int, cpu_int_num, busy
  );
  modport host (
    output cpu_trigger, polarity, enable, high_group,
    output pram_wr, pram_group, pram_addr, pram_data,
    input event_level, event_flag, cpu_int, cpu_int_num, busy
  );
endinterface
`default_nettype wire

// ===== src/edm_controller.sv
// Event capture, two group engines and crossbar arbitration.
//
// Our own choices: the register offsets and the APB register port.
`timescale 1ns/10ps
`default_nettype none
module edm_controller (
  input wire logic pclk,
  input wire logic presetn,
  edm_link_if.device lnk,
  input wire logic [3:0] timer_request,
  input wire logic [2:0] audio_tx_request,
  input wire logic [2:0] audio_rx_request,
  input wire logic host_port_cpu_int,
  input wire logic [1:0] spi_rx_request,
  input wire logic [1:0] twi_tx_event,
  input wire logic [1:0] twi_rx_event,
  input wire logic [2:0] audio_mute_input,
  input wire logic [2:0] audio_tx_int,
  input wire logic [2:0] audio_rx_int,
  input wire logic timer_overflow_error,
  output logic xbar_valid,
  output logic xbar_we,
  output logic [31:0] xbar_addr,
  output logic [31:0] xbar_wdata,
  input wire logic [31:0] xbar_rdata,
  input wire logic xbar_ready,
  input wire logic other_req,
  output logic other_gnt
);
  typedef enum logic [1:0] {S_IDLE, S_LOAD, S_READ, S_WRITE} edm_state_type;

  // Lowest set bit wins.
  function automatic logic [4:0] edm_lowest(input logic [31:0] v);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 31; i >= 0; i--)
    begin
      if (v[i])
        r = 5'(i);
    end
    return r;
  endfunction

  function automatic logic [5:0] edm_xaddr(input logic [2:0] p,
                                           input logic [1:0] w);
    return {1'b1, p, w};
  endfunction

  logic [31:0] src_vec;
  logic [31:0] level_r;
  logic [31:0] prev_r;
  logic [31:0] flag_r;
  logic [31:0] flag_set;
  logic [31:0] clr_all;
  logic [31:0] eng_clr [2];
  logic eng_req [2];
  logic eng_we [2];
  logic [31:0] eng_addr [2];
  logic [31:0] eng_wdata [2];
  logic int_r [2];
  logic [3:0] num_r [2];
  logic busy_r [2];
  wire [31:0] cur_src [2];
  wire [31:0] cur_dst [2];
  logic [1:0] ack_r;
  logic [31:0] rdata_r;
  logic owner_r;
  logic bus_valid_r;
  logic bus_we_r;
  logic [31:0] bus_addr_r;
  logic [31:0] bus_wdata_r;
  logic other_gnt_r;

  // Event source wiring.
  always_comb
  begin
    src_vec = 32'h0000_0000;
    src_vec[0] = lnk.cpu_trigger[0];
    src_vec[1] = lnk.cpu_trigger[16];
    src_vec[10] = lnk.cpu_trigger[1];
    src_vec[11] = lnk.cpu_trigger[17];
    src_vec[17] = lnk.cpu_trigger[2];
    src_vec[18] = lnk.cpu_trigger[18];
    src_vec[23] = lnk.cpu_trigger[3];
    src_vec[24] = lnk.cpu_trigger[19];
    src_vec[30] = lnk.cpu_trigger[20];
    src_vec[31] = lnk.cpu_trigger[21];
    src_vec[2] = timer_request[0];
    src_vec[3] = timer_request[1];
    src_vec[15] = timer_request[2];
    src_vec[16] = timer_request[3];
    src_vec[12] = host_port_cpu_int;
    src_vec[13] = spi_rx_request[0];
    src_vec[14] = spi_rx_request[1];
    src_vec[19] = twi_tx_event[0];
    src_vec[20] = twi_rx_event[0];
    src_vec[21] = twi_tx_event[1];
    src_vec[22] = twi_rx_event[1];
    src_vec[29] = timer_overflow_error;
    for (int i = 0; i < 3; i++)
    begin
      src_vec[4 + 2 * i] = audio_tx_request[i];
      src_vec[5 + 2 * i] = audio_rx_request[i];
      src_vec[26 + i] = audio_mute_input[i] | audio_tx_int[i]
                        | audio_rx_int[i];
    end
  end

  // Level mirror and edge capture.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      level_r <= edm_pkg::RST_ZERO;
      prev_r <= edm_pkg::RST_ZERO;
    end
    else
    begin
      level_r <= src_vec & edm_pkg::EV_VALID_MASK;
      prev_r <= level_r;
    end
  end

  assign flag_set = lnk.enable & edm_pkg::EV_VALID_MASK
                    & ((lnk.polarity & level_r & ~prev_r)
                    | (~lnk.polarity & ~level_r & prev_r));
  assign clr_all = eng_clr[0] | eng_clr[1];

  // A new edge wins over a dispatch clear.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      flag_r <= edm_pkg::RST_ZERO;
    else
      flag_r <= (flag_r & ~clr_all) | flag_set;
  end

  for (genvar g = 0; g < 2; g++)
  begin : gen_eng
    logic [31:0] pram [edm_pkg::PRAM_WORDS];
    edm_state_type st_r;
    logic [4:0] ev_r;
    logic [31:0] src_r;
    logic [31:0] dst_r;
    logic [15:0] cnt_r;
    logic [15:0] sidx_r;
    logic [15:0] didx_r;
    logic [31:0] pend;
    logic [31:0] ent;
    logic [2:0] ptr;
    logic [31:0] nsrc;
    logic [31:0] ndst;
    logic conflict;

    assign pend = (g == 0) ? (flag_r & lnk.high_group)
                           : (flag_r & ~lnk.high_group);
    assign ent = pram[{1'b0, ev_r}];
    assign ptr = ent[edm_pkg::ENT_PTR_POS +: 3];
    assign nsrc = pram[edm_xaddr(ptr, edm_pkg::XW_SRC)];
    assign ndst = pram[edm_xaddr(ptr, edm_pkg::XW_DST)];
    assign conflict = (g == 1) && busy_r[0]
                      && (nsrc == cur_src[0] || ndst == cur_dst[0]);
    assign cur_src[g] = src_r;
    assign cur_dst[g] = dst_r;

    always_ff @(posedge pclk)
    begin
      if (lnk.pram_wr && (lnk.pram_group == 1'(g)))
        pram[lnk.pram_addr] <= lnk.pram_data;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        st_r <= S_IDLE;
        ev_r <= 5'h00;
        src_r <= 32'h0000_0000;
        dst_r <= 32'h0000_0000;
        cnt_r <= 16'h0000;
        sidx_r <= 16'h0000;
        didx_r <= 16'h0000;
        eng_clr[g] <= 32'h0000_0000;
        eng_req[g] <= 1'b0;
        eng_we[g] <= 1'b0;
        eng_addr[g] <= 32'h0000_0000;
        eng_wdata[g] <= 32'h0000_0000;
        int_r[g] <= 1'b0;
        num_r[g] <= 4'h0;
        busy_r[g] <= 1'b0;
      end
      else
      begin
        eng_clr[g] <= 32'h0000_0000;
        int_r[g] <= 1'b0;
        unique case (st_r)
          S_IDLE:
            if (|pend)
            begin
              ev_r <= edm_lowest(pend);
              eng_clr[g] <= 32'h0000_0001 << edm_lowest(pend);
              busy_r[g] <= 1'b1;
              st_r <= S_LOAD;
            end
          S_LOAD:
            unique case (ent[edm_pkg::ENT_TYPE_POS +: 2])
              edm_pkg::ET_XFER:
                if (!conflict)
                begin
                  src_r <= nsrc;
                  dst_r <= ndst;
                  cnt_r <= pram[edm_xaddr(ptr, edm_pkg::XW_CNT)][15:0];
                  sidx_r <= pram[edm_xaddr(ptr, edm_pkg::XW_IDX)][15:0];
                  didx_r <= pram[edm_xaddr(ptr, edm_pkg::XW_IDX)][31:16];
                  if (pram[edm_xaddr(ptr, edm_pkg::XW_CNT)][15:0] == 16'h0000)
                  begin
                    busy_r[g] <= 1'b0;
                    st_r <= S_IDLE;
                  end
                  else
                  begin
                    eng_req[g] <= 1'b1;
                    eng_we[g] <= 1'b0;
                    eng_addr[g] <= nsrc;
                    st_r <= S_READ;
                  end
                end
              edm_pkg::ET_INT:
              begin
                int_r[g] <= 1'b1;
                num_r[g] <= ent[edm_pkg::ENT_IRQ_POS +: 4];
                busy_r[g] <= 1'b0;
                st_r <= S_IDLE;
              end
              default:
              begin
                busy_r[g] <= 1'b0;
                st_r <= S_IDLE;
              end
            endcase
          S_READ:
            if (ack_r[g])
            begin
              eng_we[g] <= 1'b1;
              eng_addr[g] <= dst_r;
              eng_wdata[g] <= rdata_r;
              st_r <= S_WRITE;
            end
          S_WRITE:
            if (ack_r[g])
            begin
              src_r <= src_r + {{16{sidx_r[15]}}, sidx_r};
              dst_r <= dst_r + {{16{didx_r[15]}}, didx_r};
              cnt_r <= cnt_r - 16'h0001;
              eng_we[g] <= 1'b0;
              eng_addr[g] <= src_r + {{16{sidx_r[15]}}, sidx_r};
              if (cnt_r == 16'h0001)
              begin
                eng_req[g] <= 1'b0;
                busy_r[g] <= 1'b0;
                st_r <= S_IDLE;
              end
              else
                st_r <= S_READ;
            end
        endcase
      end
    end
  end

  // Crossbar port arbitration, fixed priority at grant time.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bus_valid_r <= 1'b0;
      bus_we_r <= 1'b0;
      bus_addr_r <= 32'h0000_0000;
      bus_wdata_r <= 32'h0000_0000;
      owner_r <= 1'b0;
      ack_r <= 2'h0;
      rdata_r <= 32'h0000_0000;
      other_gnt_r <= 1'b0;
    end
    else
    begin
      ack_r <= 2'h0;
      if (bus_valid_r)
      begin
        if (xbar_ready)
        begin
          bus_valid_r <= 1'b0;
          ack_r[owner_r] <= 1'b1;
          rdata_r <= xbar_rdata;
        end
      end
      else if (other_gnt_r)
      begin
        if (!other_req)
          other_gnt_r <= 1'b0;
      end
      else if (eng_req[0] && !ack_r[0])
      begin
        bus_valid_r <= 1'b1;
        bus_we_r <= eng_we[0];
        bus_addr_r <= eng_addr[0];
        bus_wdata_r <= eng_wdata[0];
        owner_r <= 1'b0;
      end
      else if (eng_req[1] && !ack_r[1])
      begin
        bus_valid_r <= 1'b1;
        bus_we_r <= eng_we[1];
        bus_addr_r <= eng_addr[1];
        bus_wdata_r <= eng_wdata[1];
        owner_r <= 1'b1;
      end
      else if (other_req)
        other_gnt_r <= 1'b1;
    end
  end

  assign xbar_valid = bus_valid_r;
  assign xbar_we = bus_we_r;
  assign xbar_addr = bus_addr_r;
  assign xbar_wdata = bus_wdata_r;
  assign other_gnt = other_gnt_r;
  assign lnk.event_level = level_r;
  assign lnk.event_flag = flag_r;
  assign lnk.cpu_int = {int_r[1], int_r[0]};
  assign lnk.cpu_int_num = {num_r[1], num_r[0]};
  assign lnk.busy = {busy_r[1], busy_r[0]};
endmodule
`default_nettype wire

// ===== src/edm_cpu_port.sv
// CPU-side end: APB registers that steer the controller.
`timescale 1ns/10ps
`default_nettype none
module edm_cpu_port (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  edm_link_if.host lnk
);
  logic [31:0] trig_r;
  logic [31:0] pol_r;
  logic [31:0] en_r;
  logic [31:0] grp_r;
  logic [8:0] paddr_r;
  logic [31:0] pdata_r;
  logic pwr_r;
  logic [15:0] irq_r;
  logic [15:0] irq_set;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic wr_take;
  logic [31:0] rd_val;
  logic hit;

  assign wr_take = psel & penable & pready_r & pwrite & hit;
  assign irq_set = ({15'h0000, lnk.cpu_int[0]} << lnk.cpu_int_num[3:0])
                   | ({15'h0000, lnk.cpu_int[1]} << lnk.cpu_int_num[7:4]);

  always_comb
  begin
    hit = 1'b1;
    rd_val = 32'h0000_0000;
    unique case (paddr)
      edm_pkg::REG_TRIGGER: rd_val = trig_r;
      edm_pkg::REG_POLARITY: rd_val = pol_r;
      edm_pkg::REG_ENABLE: rd_val = en_r;
      edm_pkg::REG_HIGH_GROUP: rd_val = grp_r;
      edm_pkg::REG_PRAM_ADDR: rd_val = {23'h000000, paddr_r};
      edm_pkg::REG_PRAM_DATA: rd_val = pdata_r;
      edm_pkg::REG_LEVEL: rd_val = lnk.event_level;
      edm_pkg::REG_FLAG: rd_val = lnk.event_flag;
      edm_pkg::REG_IRQ: rd_val = {16'h0000, irq_r};
      edm_pkg::REG_BUSY: rd_val = {30'h00000000, lnk.busy};
      default: hit = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end
    else
    begin
      pready_r <= psel & penable & ~pready_r;
      if (psel & penable & ~pready_r)
      begin
        prdata_r <= pwrite ? 32'h0000_0000 : rd_val;
        pslverr_r <= ~hit;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      trig_r <= edm_pkg::RST_ZERO;
      pol_r <= edm_pkg::RST_POLARITY;
      en_r <= edm_pkg::RST_ZERO;
      grp_r <= edm_pkg::RST_ZERO;
    end
    else if (wr_take)
    begin
      if (paddr == edm_pkg::REG_TRIGGER)
        trig_r <= pwdata;
      if (paddr == edm_pkg::REG_POLARITY)
        pol_r <= pwdata;
      if (paddr == edm_pkg::REG_ENABLE)
        en_r <= pwdata;
      if (paddr == edm_pkg::REG_HIGH_GROUP)
        grp_r <= pwdata;
    end
  end

  // Parameter RAM write port with address auto-increment.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      paddr_r <= 9'h000;
      pdata_r <= edm_pkg::RST_ZERO;
      pwr_r <= 1'b0;
    end
    else
    begin
      pwr_r <= wr_take && (paddr == edm_pkg::REG_PRAM_DATA);
      if (wr_take && (paddr == edm_pkg::REG_PRAM_ADDR))
        paddr_r <= pwdata[8:0];
      else if (pwr_r)
        paddr_r[5:0] <= paddr_r[5:0] + 6'h01;
      if (wr_take && (paddr == edm_pkg::REG_PRAM_DATA))
        pdata_r <= pwdata;
    end
  end

  // Interrupt records; a new interrupt wins over a write-one clear.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_r <= 16'h0000;
    else if (wr_take && (paddr == edm_pkg::REG_IRQ))
      irq_r <= (irq_r & ~pwdata[15:0]) | irq_set;
    else
      irq_r <= irq_r | irq_set;
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign lnk.cpu_trigger = trig_r;
  assign lnk.polarity = pol_r;
  assign lnk.enable = en_r;
  assign lnk.high_group = grp_r;
  assign lnk.pram_wr = pwr_r;
  assign lnk.pram_group = paddr_r[edm_pkg::PRAM_GROUP_POS];
  assign lnk.pram_addr = paddr_r[5:0];
  assign lnk.pram_data = pdata_r;
endmodule
`default_nettype wire

// ===== tb/edm_link_assertions.sv
// Checker on the link between the CPU port and the controller.
`timescale 1ns/10ps
`default_nettype none
module edm_link_assertions (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [31:0] cpu_trigger,
  input wire logic [31:0] polarity,
  input wire logic [31:0] enable,
  input wire logic [31:0] high_group,
  input wire logic pram_wr,
  input wire logic [31:0] event_level,
  input wire logic [31:0] event_flag,
  input wire logic [1:0] cpu_int,
  input wire logic [1:0] busy
);
  logic [31:0] flag_r;
  logic [31:0] flag2_r;
  logic [31:0] hg_r;
  logic [31:0] clr_hi;
  logic [31:0] clr_lo;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Keeps older flag images to see which flags were dispatched.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      flag_r <= 32'h0000_0000;
      flag2_r <= 32'h0000_0000;
      hg_r <= 32'h0000_0000;
    end
    else
    begin
      flag_r <= event_flag;
      flag2_r <= flag_r;
      hg_r <= high_group;
    end
  end
  assign clr_hi = flag_r & ~event_flag & hg_r;
  assign clr_lo = flag_r & ~event_flag & ~hg_r;
  a_trigger_level_map: assert property ({event_level[0], event_level[1],
    event_level[10], event_level[11], event_level[17], event_level[18],
    event_level[23], event_level[24], event_level[30], event_level[31]}
    == $past({cpu_trigger[0], cpu_trigger[16], cpu_trigger[1],
    cpu_trigger[17], cpu_trigger[2], cpu_trigger[18], cpu_trigger[3],
    cpu_trigger[19], cpu_trigger[20], cpu_trigger[21]}))
    else $error("trigger bits do not reach their events");
  a_reserved_quiet: assert property (!event_level[25] && !event_flag[25])
    else $error("reserved event became active");
  a_flag_needs_edge: assert property ((event_flag & ~flag_r & ~($past(enable)
    & ($past(event_level) ^ $past(event_level, 2))
    & ~($past(event_level) ^ $past(polarity)))) == 32'h0000_0000)
    else $error("flag set without a matching edge");
  a_hi_int_pulse: assert property (cpu_int[0] |=> !cpu_int[0])
    else $error("high interrupt pulse too long");
  a_lo_int_pulse: assert property (cpu_int[1] |=> !cpu_int[1])
    else $error("low interrupt pulse too long");
  a_hi_one_clear: assert property ($countones(clr_hi) <= 1)
    else $error("two high events dispatched at once");
  a_lo_one_clear: assert property ($countones(clr_lo) <= 1)
    else $error("two low events dispatched at once");
  a_hi_lowest_first: assert property ((clr_hi != 0) |->
    ((clr_hi - 32'h0000_0001) & flag2_r & hg_r) == 32'h0000_0000)
    else $error("high group skipped a lower event");
  a_lo_lowest_first: assert property ((clr_lo != 0) |->
    ((clr_lo - 32'h0000_0001) & flag2_r & ~hg_r) == 32'h0000_0000)
    else $error("low group skipped a lower event");
  a_hi_engine_busy: assert property ((clr_hi != 0) |-> $past(busy[0]))
    else $error("high dispatch without high engine");
  a_lo_engine_busy: assert property ((clr_lo != 0) |-> $past(busy[1]))
    else $error("low dispatch without low engine");
  a_pram_pulse: assert property (pram_wr |=> !pram_wr)
    else $error("entry write pulse too long");
endmodule
`default_nettype wire

// ===== tb/tb.sv
// Self-checking bench for the event controller and its CPU port.
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, xbar_addr, xbar_wdata;
  logic pready, pslverr, xbar_valid, xbar_we, other_gnt;
  logic [26:0] per_in = 27'h000_0000;
  logic [31:0] xbar_rdata = 32'h5A5A_5A5A;
  logic xbar_ready = 1'h0;
  logic other_req = 1'h0;
  logic both_seen = 1'h0;
  logic [31:0] mem [logic [31:0]];
  logic [3:0] hiq [$];
  logic [3:0] loq [$];
  int bad_count = 0;
  int tests_run = 0;
  int cyc = 0;
  int tbit [10] = '{0, 16, 1, 17, 2, 18, 3, 19, 20, 21};
  int tev [10] = '{0, 1, 10, 11, 17, 18, 23, 24, 30, 31};
  int iev [5] = '{0, 10, 17, 1, 11};
  int irq [5] = '{5, 3, 14, 2, 7};
  edm_link_if lnk ();
  edm_cpu_port u_edm_cpu_port (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .lnk(lnk));
  edm_controller u_edm_controller (.pclk(pclk), .presetn(presetn),
    .lnk(lnk), .timer_request(per_in[3:0]),
    .audio_tx_request(per_in[6:4]), .audio_rx_request(per_in[9:7]),
    .host_port_cpu_int(per_in[10]), .spi_rx_request(per_in[12:11]),
    .twi_tx_event(per_in[14:13]), .twi_rx_event(per_in[16:15]),
    .audio_mute_input(per_in[19:17]), .audio_tx_int(per_in[22:20]),
    .audio_rx_int(per_in[25:23]), .timer_overflow_error(per_in[26]),
    .xbar_valid(xbar_valid), .xbar_we(xbar_we), .xbar_addr(xbar_addr),
    .xbar_wdata(xbar_wdata), .xbar_rdata(xbar_rdata),
    .xbar_ready(xbar_ready), .other_req(other_req), .other_gnt(other_gnt));
  edm_link_assertions u_chk (.pclk(pclk), .presetn(presetn),
    .cpu_trigger(lnk.cpu_trigger), .polarity(lnk.polarity),
    .enable(lnk.enable), .high_group(lnk.high_group), .pram_wr(lnk.pram_wr),
    .event_level(lnk.event_level), .event_flag(lnk.event_flag),
    .cpu_int(lnk.cpu_int), .busy(lnk.busy));
  always #2 pclk = ~pclk;
  task automatic close_out();
    $display("Comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] s,
    input logic [31:0] x);
    tests_run++;
    if (s !== x)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, x, s);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d, output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'h1, a, d, r, e);
  endtask
  task automatic rdck(input string nm, input logic [11:0] a,
    input logic [31:0] x);
    logic [31:0] r;
    logic e;
    apb(1'h0, a, 32'h0000_0000, r, e);
    check(nm, r, x);
  endtask
  task automatic pw(input logic g, input logic [5:0] a, input logic [31:0] d);
    wr(edm_pkg::REG_PRAM_ADDR, {23'h00_0000, g, 2'h0, a});
    wr(edm_pkg::REG_PRAM_DATA, d);
  endtask
  task automatic wait_idle();
    logic [31:0] f, b;
    logic e;
    repeat (8) @(posedge pclk);
    do
    begin
      apb(1'h0, edm_pkg::REG_FLAG, 32'h0000_0000, f, e);
      apb(1'h0, edm_pkg::REG_BUSY, 32'h0000_0000, b, e);
    end
    while (f !== 32'h0000_0000 || b !== 32'h0000_0000);
  endtask
  function automatic logic [31:0] exp_level(input logic [26:0] p);
    logic [31:0] v;
    v = 32'h0000_0000;
    v[3:2] = p[1:0];
    v[16:15] = p[3:2];
    for (int k = 0; k < 3; k++)
    begin
      v[4 + 2 * k] = p[4 + k];
      v[5 + 2 * k] = p[7 + k];
      v[26 + k] = p[17 + k] | p[20 + k] | p[23 + k];
    end
    v[14:12] = p[12:10];
    v[22:19] = {p[16], p[14], p[15], p[13]};
    v[29] = p[26];
    return v;
  endfunction
  // Slave port model with random wait states and a scrambled idle bus.
  always @(posedge pclk)
  begin
    if (xbar_valid === 1'h1 && xbar_ready !== 1'h1 && $urandom_range(2, 0) == 0)
    begin
      xbar_ready <= 1'h1;
      xbar_rdata <= mem.exists(xbar_addr) ? mem[xbar_addr] : 32'h0000_0000;
    end
    else
    begin
      xbar_ready <= 1'h0;
      xbar_rdata <= ~xbar_rdata;
    end
    if (xbar_valid === 1'h1 && xbar_ready === 1'h1 && xbar_we === 1'h1)
      mem[xbar_addr] = xbar_wdata;
  end
  // Other master, interrupt capture and timeout.
  always @(posedge pclk)
  begin
    cyc++;
    if (presetn === 1'h1 && $urandom_range(15, 0) == 0)
      other_req <= ~other_req;
    if (lnk.busy === 2'h3)
      both_seen <= 1'h1;
    if (lnk.cpu_int[0] === 1'h1)
      hiq.push_back(lnk.cpu_int_num[3:0]);
    if (lnk.cpu_int[1] === 1'h1)
      loq.push_back(lnk.cpu_int_num[7:4]);
    if (other_gnt === 1'h1)
      check("grant", {31'h0, xbar_valid}, 32'h0000_0000);
    if (cyc == 30000)
    begin
      bad_count++;
      close_out();
    end
  end
  initial
  begin
    logic [31:0] pv, r, ix;
    logic e;
    logic [3:0] eh [$];
    logic [3:0] el [$];
    logic [31:0] sv [$];
    void'($urandom(52));
    repeat (12) @(posedge pclk);
    presetn <= 1'h1;
    rdck("polarity", edm_pkg::REG_POLARITY, edm_pkg::RST_POLARITY);
    rdck("flag", edm_pkg::REG_FLAG, edm_pkg::RST_ZERO);
    apb(1'h0, 12'h100, 32'h0000_0000, r, e);
    check("slverr", {31'h0, e}, 32'h0000_0001);
    for (int i = 0; i < 10; i++)
    begin
      wr(edm_pkg::REG_TRIGGER, 32'h0000_0001 << tbit[i]);
      rdck("level", edm_pkg::REG_LEVEL, 32'h0000_0001 << tev[i]);
    end
    wr(edm_pkg::REG_TRIGGER, 32'h0000_0000);
    rdck("flag_off", edm_pkg::REG_FLAG, 32'h0000_0000);
    for (int k = 0; k < 4; k++)
    begin
      pv = $urandom;
      per_in <= pv[26:0];
      rdck("periph", edm_pkg::REG_LEVEL, exp_level(pv[26:0]));
    end
    per_in <= 27'h000_0000;
    ix = 32'h0000_0000;
    for (int i = 0; i < 5; i++)
      pw(i > 2, 6'(iev[i]), (32'(irq[i]) << 8) | 32'h0000_0002);
    for (int k = 0; k < 32; k++)
      for (int i = 0; i < 5; i++)
        if (iev[i] == k)
        begin
          if (i < 3)
            eh.push_back(4'(irq[i]));
          else
            el.push_back(4'(irq[i]));
          ix = ix | (32'h0000_0001 << irq[i]);
        end
    pw(1'h0, 6'h3C, 32'h0000_1000);
    wr(edm_pkg::REG_PRAM_DATA, 32'h0000_2000);
    wr(edm_pkg::REG_PRAM_DATA, 32'h0000_0003);
    wr(edm_pkg::REG_PRAM_DATA, 32'h0004_0004);
    pw(1'h1, 6'h20, 32'h0000_3000);
    wr(edm_pkg::REG_PRAM_DATA, 32'h0000_4000);
    wr(edm_pkg::REG_PRAM_DATA, 32'h0000_0002);
    wr(edm_pkg::REG_PRAM_DATA, 32'h0004_0004);
    pw(1'h0, 6'h17, 32'h0000_001D);
    pw(1'h1, 6'h18, 32'h0000_0001);
    wr(edm_pkg::REG_HIGH_GROUP, 32'h0082_0401);
    wr(edm_pkg::REG_ENABLE, 32'h0182_0C03);
    wr(edm_pkg::REG_TRIGGER, 32'h0003_0007);
    wait_idle();
    check("hi_count", 32'(hiq.size()), 32'(eh.size()));
    check("lo_count", 32'(loq.size()), 32'(el.size()));
    for (int k = 0; k < eh.size(); k++)
      check("hi_irq", {28'h0, hiq[k]}, {28'h0, eh[k]});
    for (int k = 0; k < el.size(); k++)
      check("lo_irq", {28'h0, loq[k]}, {28'h0, el[k]});
    rdck("irq", edm_pkg::REG_IRQ, ix);
    wr(edm_pkg::REG_IRQ, ix);
    rdck("irq_clr", edm_pkg::REG_IRQ, 32'h0000_0000);
    for (int k = 0; k < 5; k++)
    begin
      sv.push_back($urandom);
      mem[(k < 3) ? 32'h1000 + 4 * k : 32'h3000 + 4 * (k - 3)] = sv[k];
    end
    wr(edm_pkg::REG_POLARITY, 32'hFEFF_FFFF);
    wr(edm_pkg::REG_TRIGGER, 32'h000B_000F);
    wr(edm_pkg::REG_TRIGGER, 32'h0003_000F);
    wait_idle();
    for (int k = 0; k < 5; k++)
      check("copy", mem[(k < 3) ? 32'h2000 + 4 * k : 32'h4000 + 4 * (k - 3)],
        sv[k]);
    check("overlap", {31'h0, both_seen}, 32'h0000_0001);
    rdck("flag_done", edm_pkg::REG_FLAG, 32'h0000_0000);
    close_out();
  end
endmodule
`default_nettype wire
